/* src/efm_alarm_monitor.sv */
// Contract
// - All block registers except config held reset when line standard is 0 or unframed is 1.
// - Persistence on: remote alarm sets after four ones in a row, clears on zero.
// - Persistence off: remote alarm follows each received alarm bit directly.
// - Remote alarm status refreshes once every two frames.
// - Multiframe alarm sets after three ones in a row, clears on any zero.
// - Multiframe alarm status refreshes once every sixteen frames.
// - Persistence off: detect sets on window with two or fewer zeros, clears on more.
// - Persistence on: detect needs two consecutive windows of same kind to change.
// - Zero density detect updates only at end of each 512-bit window.
// - Loss-of-frame alarm follows out-of-frame persisting 100 ms either way.
// - All-ones alarm follows out-of-frame all-ones persisting 100 ms either way.
// - First bit of alignment frame timeslot 0 captured to bit 7 at frame pulse.
// - Non-alignment frame bits captured to bits 6 to 0 at frame pulse.
// - Ten-bit CRC error count transferred each second into two readable registers.
// - Fresh flag sets on transfer, clears on read of upper counter register.
// - Overrun flag sets when transfer precedes read, clears on upper read.
// - Timeslot 16 frame 0 bits 5 to 8 captured into upper register bits 5 to 2.
// - Timeslot 16 extra bits frozen while out of frame alignment.
// - Frame pulse event at timeslot 1 bit 1 times all captures.
// - Codeword select 100..111 pick national bits 4..7, 000 picks bit 8.
// - Enabled national bit with change indication drives active-low interrupt.
`timescale 1ns/1ps
`default_nettype none
module efm_alarm_monitor
  import efm_pkg::*;
#(
  parameter int ALARM_CYCLES = ALARM_CYC,
  parameter int SEC_CYCLES   = SEC_CYC
)
(
  // Clock and reset
  input  wire logic                      I_CLK,
  input  wire logic                      I_RST_N,
  // Receive stream from the framer
  input  wire logic                      I_BIT_VALID,
  input  wire logic                      I_BIT_DATA,
  input  wire logic                      I_FRAME_PULSE,
  input  wire logic                      I_ALIGN_FRAME,
  input  wire logic [7:0]                I_TS0_BYTE,
  input  wire logic                      I_SMF_FRAME0,
  input  wire logic [7:0]                I_TS16_BYTE,
  input  wire logic                      I_OUT_OF_FRAME,
  input  wire logic                      I_ALL_ONES,
  input  wire logic                      I_CRC_ERROR,
  input  wire logic [4:0]                I_NAT_CHANGE,
  // AXI4-Lite write
  input  wire logic [efm_pkg::ADDR_W-1:0] I_AWADDR,
  input  wire logic                      I_AWVALID,
  output logic                           O_AWREADY,
  input  wire logic [31:0]               I_WDATA,
  input  wire logic [3:0]                I_WSTRB,
  input  wire logic                      I_WVALID,
  output logic                           O_WREADY,
  output logic [1:0]                     O_BRESP,
  output logic                           O_BVALID,
  input  wire logic                      I_BREADY,
  // AXI4-Lite read
  input  wire logic [efm_pkg::ADDR_W-1:0] I_ARADDR,
  input  wire logic                      I_ARVALID,
  output logic                           O_ARREADY,
  output logic [31:0]                    O_RDATA,
  output logic [1:0]                     O_RRESP,
  output logic                           O_RVALID,
  input  wire logic                      I_RREADY,
  // Status outputs
  output logic [2:0]                     O_CODEWORD_SELECT,
  output logic                           O_IRQ_OUT_N
);
  import efm_pkg::*;

  function automatic logic [11:0] word_idx(input logic [ADDR_W-1:0] a);
    word_idx = a[ADDR_W-1:2];
  endfunction : word_idx

  logic [7:0]  cfg_q;
  logic [7:0]  nat_en_q;
  logic        blk_clr;
  assign blk_clr = !cfg_q[CFG_LINE_STD] || cfg_q[CFG_UNFRAMED];

  // AXI write path
  logic                 aw_hold_q;
  logic                 w_hold_q;
  logic [ADDR_W-1:0]    awaddr_q;
  logic [31:0]          wdata_q;
  logic [3:0]           wstrb_q;
  logic                 bvalid_q;
  logic [1:0]           bresp_q;
  logic                 wr_go;
  logic                 wr_ok;
  assign O_AWREADY = !aw_hold_q && !bvalid_q;
  assign O_WREADY  = !w_hold_q && !bvalid_q;
  assign wr_go     = aw_hold_q && w_hold_q && !bvalid_q;
  assign wr_ok     = word_idx(awaddr_q) == IDX_CONFIG || word_idx(awaddr_q) == IDX_NAT_IRQ_EN ||
                     word_idx(awaddr_q) == IDX_ALARM_STATUS || word_idx(awaddr_q) == IDX_TS0_BITS ||
                     word_idx(awaddr_q) == IDX_CRC_LOW || word_idx(awaddr_q) == IDX_CRC_HIGH ||
                     word_idx(awaddr_q) == IDX_NAT_IRQ_STAT;
  assign O_BVALID  = bvalid_q;
  assign O_BRESP   = bresp_q;

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= AXI_OKAY;
    end
    else
    begin
      if (I_AWVALID && O_AWREADY)
      begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= I_AWADDR;
      end
      if (I_WVALID && O_WREADY)
      begin
        w_hold_q <= 1'b1;
        wdata_q  <= I_WDATA;
        wstrb_q  <= I_WSTRB;
      end
      if (wr_go)
      begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_ok ? AXI_OKAY : AXI_SLVERR;
      end
      else if (bvalid_q && I_BREADY)
        bvalid_q <= 1'b0;
    end
  end

  // Config sits outside the held-reset group so software can leave that state
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      cfg_q <= CFG_RESET;
    else if (wr_go && word_idx(awaddr_q) == IDX_CONFIG && wstrb_q[0])
      cfg_q <= {4'h0, wdata_q[3:0]};
  end

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      nat_en_q <= NAT_EN_RESET;
    else if (blk_clr)
      nat_en_q <= NAT_EN_RESET;
    else if (wr_go && word_idx(awaddr_q) == IDX_NAT_IRQ_EN && wstrb_q[0])
      nat_en_q <= wdata_q[7:0];
  end

  // Codeword select decode, registered; undefined codes select nothing
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      O_CODEWORD_SELECT <= CW_SEL_RESET;
    else
    begin
      case (nat_en_q[7:5])
        3'b100:  O_CODEWORD_SELECT <= 3'h0;
        3'b101:  O_CODEWORD_SELECT <= 3'h1;
        3'b110:  O_CODEWORD_SELECT <= 3'h2;
        3'b111:  O_CODEWORD_SELECT <= 3'h3;
        3'b000:  O_CODEWORD_SELECT <= 3'h4;
        default: O_CODEWORD_SELECT <= 3'h7;
      endcase
    end
  end

  // Registered so a write to the enables cannot glitch the pin
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      O_IRQ_OUT_N <= IRQ_N_RESET;
    else
      O_IRQ_OUT_N <= !(|(nat_en_q[4:0] & I_NAT_CHANGE));
  end

  // Frame pulse marks timeslot 1 bit 1, so timeslot bytes are complete
  logic frm_pls;
  assign frm_pls = I_FRAME_PULSE && !blk_clr;

  // Remote alarm, evaluated every second frame (each non-alignment frame)
  logic       rai_q;
  logic [2:0] rai_cnt_q;
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      rai_q     <= 1'b0;
      rai_cnt_q <= 3'h0;
    end
    else if (blk_clr)
    begin
      rai_q     <= 1'b0;
      rai_cnt_q <= 3'h0;
    end
    else if (frm_pls && !I_ALIGN_FRAME)
    begin
      if (!I_TS0_BYTE[5])
      begin
        rai_q     <= 1'b0;
        rai_cnt_q <= 3'h0;
      end
      else if (!cfg_q[CFG_RAI_PERSIST])
        rai_q <= 1'b1;
      else
      begin
        if (rai_cnt_q < RAI_PERSIST_CNT)
          rai_cnt_q <= rai_cnt_q + 3'h1;
        if (rai_cnt_q + 3'h1 >= RAI_PERSIST_CNT)
          rai_q <= 1'b1;
      end
    end
  end

  // Multiframe alarm, evaluated at frame 0 of each 16-frame multiframe
  logic       rmai_q;
  logic [1:0] rmai_cnt_q;
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      rmai_q     <= 1'b0;
      rmai_cnt_q <= 2'h0;
    end
    else if (blk_clr)
    begin
      rmai_q     <= 1'b0;
      rmai_cnt_q <= 2'h0;
    end
    else if (frm_pls && I_SMF_FRAME0)
    begin
      if (!I_TS16_BYTE[2])
      begin
        rmai_q     <= 1'b0;
        rmai_cnt_q <= 2'h0;
      end
      else
      begin
        if (rmai_cnt_q != RMAI_PERSIST_CNT)
          rmai_cnt_q <= rmai_cnt_q + 2'h1;
        if (rmai_cnt_q + 2'h1 >= RMAI_PERSIST_CNT)
          rmai_q <= 1'b1;
      end
    end
  end

  // Zero density over 512-bit windows
  logic [9:0] zd_bit_q;
  logic [9:0] zd_zero_q;
  logic       zd_low;
  logic       zd_end;
  efm_zd_e    zd_st_q;
  assign zd_end = I_BIT_VALID && zd_bit_q == ZD_WIN_LAST;
  assign zd_low = (zd_zero_q + {9'h0, !I_BIT_DATA}) <= ZD_MAX_ZEROS;
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      zd_bit_q  <= 10'h000;
      zd_zero_q <= 10'h000;
    end
    else if (blk_clr)
    begin
      zd_bit_q  <= 10'h000;
      zd_zero_q <= 10'h000;
    end
    else if (I_BIT_VALID)
    begin
      zd_bit_q  <= zd_end ? 10'h000 : zd_bit_q + 10'h001;
      zd_zero_q <= zd_end ? 10'h000 : zd_zero_q + {9'h0, !I_BIT_DATA};
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      zd_st_q <= ZD_CLEAR;
    else if (blk_clr)
      zd_st_q <= ZD_CLEAR;
    else if (zd_end)
    begin
      case (zd_st_q)
        ZD_CLEAR:   zd_st_q <= !zd_low ? ZD_CLEAR : (cfg_q[CFG_ZD_PERSIST] ? ZD_PEND_ON : ZD_SET);
        ZD_PEND_ON: zd_st_q <= zd_low ? ZD_SET : ZD_CLEAR;
        ZD_SET:     zd_st_q <= zd_low ? ZD_SET : (cfg_q[CFG_ZD_PERSIST] ? ZD_PEND_OF : ZD_CLEAR);
        ZD_PEND_OF: zd_st_q <= zd_low ? ZD_SET : ZD_CLEAR;
        default:    zd_st_q <= ZD_CLEAR;
      endcase
    end
  end
  logic zd_det;
  assign zd_det = zd_st_q == ZD_SET || zd_st_q == ZD_PEND_OF;

  // 100 ms persistence integrators, one per alarm
  logic [1:0]  per_in;
  logic [1:0]  per_q;
  logic [22:0] per_cnt_q [2];
  assign per_in = {I_OUT_OF_FRAME && I_ALL_ONES, I_OUT_OF_FRAME};
  generate
    for (genvar g = 0; g < 2; g++)
    begin : g_persist
      always_ff @(posedge I_CLK or negedge I_RST_N)
      begin
        if (!I_RST_N)
        begin
          per_q[g]     <= 1'b0;
          per_cnt_q[g] <= 23'h0;
        end
        else if (blk_clr)
        begin
          per_q[g]     <= 1'b0;
          per_cnt_q[g] <= 23'h0;
        end
        else if (per_in[g] == per_q[g])
          per_cnt_q[g] <= 23'h0;
        else if (per_cnt_q[g] == 23'(ALARM_CYCLES - 1))
        begin
          per_q[g]     <= per_in[g];
          per_cnt_q[g] <= 23'h0;
        end
        else
          per_cnt_q[g] <= per_cnt_q[g] + 23'h1;
      end
    end
  endgenerate

  // Timeslot 0 and 16 captures
  logic [7:0] ts0_q;
  logic [3:0] ts16_q;
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      ts0_q  <= 8'h00;
      ts16_q <= 4'h0;
    end
    else if (blk_clr)
    begin
      ts0_q  <= 8'h00;
      ts16_q <= 4'h0;
    end
    else if (frm_pls)
    begin
      if (I_ALIGN_FRAME)
        ts0_q[7] <= I_TS0_BYTE[7];
      else
        ts0_q[6:0] <= {I_TS0_BYTE[7], I_TS0_BYTE[5:0]};
      if (I_SMF_FRAME0 && !I_OUT_OF_FRAME)
        ts16_q <= I_TS16_BYTE[3:0];
    end
  end

  // CRC error counting and one-second transfer
  logic [9:0]  crc_acc_q;
  logic [9:0]  crc_hold_q;
  logic [25:0] sec_cnt_q;
  logic        sec_tick;
  logic        fresh_q;
  logic        overrun_q;
  logic        hi_read;
  assign sec_tick = sec_cnt_q == 26'(SEC_CYCLES - 1);
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      crc_acc_q  <= 10'h000;
      crc_hold_q <= 10'h000;
      sec_cnt_q  <= 26'h0;
    end
    else if (blk_clr)
    begin
      crc_acc_q  <= 10'h000;
      crc_hold_q <= 10'h000;
      sec_cnt_q  <= 26'h0;
    end
    else
    begin
      sec_cnt_q <= sec_tick ? 26'h0 : sec_cnt_q + 26'h1;
      if (sec_tick)
      begin
        crc_hold_q <= crc_acc_q;
        crc_acc_q  <= {9'h0, I_CRC_ERROR};
      end
      else if (I_CRC_ERROR && crc_acc_q != 10'h3FF)
        crc_acc_q <= crc_acc_q + 10'h001;
    end
  end

  // Transfer wins over a read in the same cycle for fresh; that read still clears overrun
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      fresh_q   <= 1'b0;
      overrun_q <= 1'b0;
    end
    else if (blk_clr)
    begin
      fresh_q   <= 1'b0;
      overrun_q <= 1'b0;
    end
    else if (sec_tick)
    begin
      fresh_q <= 1'b1;
      if (fresh_q && !hi_read)
        overrun_q <= 1'b1;
      else if (hi_read)
        overrun_q <= 1'b0;
    end
    else if (hi_read)
    begin
      fresh_q   <= 1'b0;
      overrun_q <= 1'b0;
    end
  end

  // AXI read path
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic [7:0]  rd_byte;
  logic        rd_hit;
  assign O_ARREADY = !rvalid_q;
  assign O_RVALID  = rvalid_q;
  assign O_RDATA   = rdata_q;
  assign O_RRESP   = rresp_q;
  assign hi_read   = I_ARVALID && O_ARREADY && word_idx(I_ARADDR) == IDX_CRC_HIGH;

  always_comb
  begin
    rd_hit  = 1'b1;
    rd_byte = 8'h00;
    case (word_idx(I_ARADDR))
      IDX_ALARM_STATUS: rd_byte = {rai_q, rmai_q, zd_det, 1'b0, per_q[0], per_q[1], 2'b00};
      IDX_TS0_BITS:     rd_byte = ts0_q;
      IDX_CRC_LOW:      rd_byte = crc_hold_q[7:0];
      IDX_CRC_HIGH:     rd_byte = {overrun_q, fresh_q, ts16_q, crc_hold_q[9:8]};
      IDX_NAT_IRQ_EN:   rd_byte = nat_en_q;
      IDX_NAT_IRQ_STAT: rd_byte = {3'b000, I_NAT_CHANGE};
      IDX_CONFIG:       rd_byte = cfg_q;
      default:          rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= AXI_OKAY;
    end
    else if (I_ARVALID && O_ARREADY)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= {24'h00_0000, rd_byte};
      rresp_q  <= rd_hit ? AXI_OKAY : AXI_SLVERR;
    end
    else if (rvalid_q && I_RREADY)
      rvalid_q <= 1'b0;
  end

  a_held_reset: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    blk_clr |=> !rai_q && !rmai_q && !fresh_q && ts0_q == 8'h00)
    else $error("block state not held in reset");
  a_rai_direct: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    frm_pls && !I_ALIGN_FRAME && !cfg_q[CFG_RAI_PERSIST] |=> rai_q == $past(I_TS0_BYTE[5]))
    else $error("remote alarm does not follow bit");
  a_rai_hold: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    !(frm_pls && !I_ALIGN_FRAME) && !blk_clr |=> $stable(rai_q))
    else $error("remote alarm changed between frames");
  a_rmai_clr: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    frm_pls && I_SMF_FRAME0 && !I_TS16_BYTE[2] |=> !rmai_q)
    else $error("multiframe alarm not cleared");
  a_zd_window: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    !zd_end && !blk_clr |=> $stable(zd_det))
    else $error("detect changed inside window");
  a_fresh_set: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    sec_tick && !blk_clr |=> fresh_q)
    else $error("fresh flag not set on transfer");
  a_overrun_set: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    sec_tick && fresh_q && !hi_read && !blk_clr |=> overrun_q)
    else $error("overrun not flagged");
  a_ts16_freeze: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_OUT_OF_FRAME && !blk_clr |=> $stable(ts16_q))
    else $error("extra bits changed out of frame");
  a_irq_drive: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (nat_en_q[0] && I_NAT_CHANGE[0]) |=> !O_IRQ_OUT_N)
    else $error("interrupt not driven");
  c_rai_up:  cover property (@(posedge I_CLK) disable iff (!I_RST_N) $rose(rai_q));
  c_zd_up:   cover property (@(posedge I_CLK) disable iff (!I_RST_N) $rose(zd_det));
  c_overrun_up: cover property (@(posedge I_CLK) disable iff (!I_RST_N) $rose(overrun_q));
  c_lof_up:  cover property (@(posedge I_CLK) disable iff (!I_RST_N) $rose(per_q[0]));
endmodule : efm_alarm_monitor
`default_nettype wire

/* src/efm_pkg.sv */
package efm_pkg;
  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_ALARM_STATUS  = 12'h097;
  localparam logic [11:0] IDX_TS0_BITS      = 12'h098;
  localparam logic [11:0] IDX_CRC_LOW       = 12'h099;
  localparam logic [11:0] IDX_CRC_HIGH      = 12'h09A;
  localparam logic [11:0] IDX_NAT_IRQ_EN    = 12'h09B;
  localparam logic [11:0] IDX_NAT_IRQ_STAT  = 12'h09C;
  localparam logic [11:0] IDX_CONFIG        = 12'h0C0;
  localparam int          ADDR_W            = 14;
  // Config register bit positions
  localparam int          CFG_LINE_STD      = 0;
  localparam int          CFG_UNFRAMED      = 1;
  localparam int          CFG_RAI_PERSIST   = 2;
  localparam int          CFG_ZD_PERSIST    = 3;
  localparam logic [7:0]  CFG_RESET         = 8'h01;
  localparam logic [7:0]  NAT_EN_RESET      = 8'h00;
  localparam logic [2:0]  CW_SEL_RESET      = 3'h4;
  localparam logic        IRQ_N_RESET       = 1'b1;
  // Timing
  localparam int          CLK_HZ            = 50000000;
  localparam int          ONE_SEC_MS        = 1000;
  localparam int          ALARM_MS          = 100;
  localparam int          ALARM_CYC         = CLK_HZ / 1000 * ALARM_MS;
  localparam int          SEC_CYC           = CLK_HZ / 1000 * ONE_SEC_MS;
  localparam int          ZD_WINDOW_BITS    = 512;
  localparam logic [9:0]  ZD_WIN_LAST       = 10'h1FF;
  localparam logic [9:0]  ZD_MAX_ZEROS      = 10'h002;
  localparam logic [2:0]  RAI_PERSIST_CNT   = 3'h4;
  localparam logic [1:0]  RMAI_PERSIST_CNT  = 2'h3;
  localparam logic [3:0]  FRAMES_PER_SMF    = 4'hF;
  localparam logic [1:0]  AXI_OKAY          = 2'h0;
  localparam logic [1:0]  AXI_SLVERR        = 2'h2;
  typedef enum logic [1:0]
  {
    ZD_CLEAR   = 2'b00,
    ZD_PEND_ON = 2'b01,
    ZD_SET     = 2'b10,
    ZD_PEND_OF = 2'b11
  } efm_zd_e;
endpackage : efm_pkg

/* verification/efm_line_model.sv */
`timescale 1ns/1ps
`default_nettype none
module efm_line_model
#(
  parameter int FRAME_CYC = 8
)
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Frame content
  input  wire logic       i_align_si,
  input  wire logic [7:0] i_nonalign,
  input  wire logic [3:0] i_ts16,
  input  wire logic       i_ones,
  // Framed stream
  output logic            o_pulse,
  output logic            o_align,
  output logic            o_smf0,
  output logic [7:0]      o_ts0,
  output logic [7:0]      o_ts16,
  output logic            o_bit
);
  logic [7:0] cyc_q;
  logic [3:0] frm_q;
  logic [7:0] ts0_v;
  logic [7:0] ts16_v;
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cyc_q <= 8'h00;
      frm_q <= 4'h0;
    end
    else if (cyc_q == 8'(FRAME_CYC - 1))
    begin
      cyc_q <= 8'h00;
      frm_q <= frm_q + 4'h1;
    end
    else
      cyc_q <= cyc_q + 8'h01;
  end
  assign o_pulse = i_rst_n && (cyc_q == 8'h00);
  assign o_align = ~frm_q[0];
  assign o_smf0  = (frm_q == 4'h0);
  assign ts0_v   = o_align ? {i_align_si, 7'h1B} : {i_nonalign[7], 1'b1, i_nonalign[5:0]};
  assign ts16_v  = o_smf0 ? {4'h0, i_ts16} : {4'hF, ~i_ts16};
  // Bytes mean nothing off the pulse; inverse shows a capture at the wrong time
  assign o_ts0   = o_pulse ? ts0_v : ~ts0_v;
  assign o_ts16  = o_pulse ? ts16_v : ~ts16_v;
  // Alternating data gives plenty of zeros per window
  assign o_bit   = i_ones | cyc_q[0];
endmodule : efm_line_model
`default_nettype wire

/* verification/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) check_val(32'(g), 32'(e))
module testbench;
  import efm_pkg::*;
  localparam logic [13:0] A_ALM = {IDX_ALARM_STATUS, 2'b00};
  localparam logic [13:0] A_TS0 = {IDX_TS0_BITS, 2'b00};
  localparam logic [13:0] A_LO  = {IDX_CRC_LOW, 2'b00};
  localparam logic [13:0] A_HI  = {IDX_CRC_HIGH, 2'b00};
  localparam logic [13:0] A_NEN = {IDX_NAT_IRQ_EN, 2'b00};
  localparam logic [13:0] A_CFG = {IDX_CONFIG, 2'b00};
  logic        clk, rst_n, oof, all1, crc_err, align_si, ones;
  logic [7:0]  nonalign, ts0_b, ts16_b;
  logic [3:0]  ts16;
  logic [4:0]  nat_chg;
  logic [13:0] aw_addr, ar_addr;
  logic [31:0] w_data, rdata, rd;
  logic        aw_valid, w_valid, b_ready, ar_valid, r_ready;
  logic        awready, wready, bvalid, arready, rvalid, irq_n;
  logic [1:0]  bresp, rresp, resp;
  logic [2:0]  cw_sel;
  logic        pulse, align, smf0, bit_d;
  int          failures, checks;

  efm_line_model #(.FRAME_CYC(8)) u_line (
    .i_clk(clk), .i_rst_n(rst_n), .i_align_si(align_si), .i_nonalign(nonalign), .i_ts16(ts16),
    .i_ones(ones), .o_pulse(pulse), .o_align(align), .o_smf0(smf0), .o_ts0(ts0_b),
    .o_ts16(ts16_b), .o_bit(bit_d)
  );
  efm_alarm_monitor #(.ALARM_CYCLES(20), .SEC_CYCLES(1000)) u_dut (
    .I_CLK(clk), .I_RST_N(rst_n), .I_BIT_VALID(1'b1), .I_BIT_DATA(bit_d),
    .I_FRAME_PULSE(pulse), .I_ALIGN_FRAME(align), .I_TS0_BYTE(ts0_b), .I_SMF_FRAME0(smf0),
    .I_TS16_BYTE(ts16_b), .I_OUT_OF_FRAME(oof), .I_ALL_ONES(all1), .I_CRC_ERROR(crc_err),
    .I_NAT_CHANGE(nat_chg), .I_AWADDR(aw_addr), .I_AWVALID(aw_valid), .O_AWREADY(awready),
    .I_WDATA(w_data), .I_WSTRB(4'hF), .I_WVALID(w_valid), .O_WREADY(wready), .O_BRESP(bresp),
    .O_BVALID(bvalid), .I_BREADY(b_ready), .I_ARADDR(ar_addr), .I_ARVALID(ar_valid),
    .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(r_ready),
    .O_CODEWORD_SELECT(cw_sel), .O_IRQ_OUT_N(irq_n)
  );

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t got %h exp %h", $time, got, exp);
    end
  endtask : check_val

  task automatic wrap_up;
    $display("Checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  task automatic time_out;
    failures++;
    wrap_up();
  endtask : time_out

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // Ready and answer are sampled mid-cycle; they only move at rising edges
  task automatic bus(input logic wr, input logic [13:0] a, input logic [7:0] d);
    int   n;
    logic a_t, w_t, done;
    n = 0;
    aw_addr  <= a;
    ar_addr  <= a;
    w_data   <= {24'h000000, d};
    aw_valid <= wr;
    w_valid  <= wr;
    b_ready  <= wr;
    ar_valid <= ~wr;
    r_ready  <= ~wr;
    do
    begin
      @(negedge clk);
      a_t  = wr ? (aw_valid & awready) : (ar_valid & arready);
      w_t  = w_valid & wready;
      done = wr ? (b_ready & bvalid) : (r_ready & rvalid);
      resp = wr ? bresp : rresp;
      rd   = rdata;
      @(posedge clk);
      if (a_t)
        {aw_valid, ar_valid} <= 2'b00;
      if (w_t)
        w_valid <= 1'b0;
      if (done)
        {b_ready, r_ready} <= 2'b00;
      n++;
      if (n > 60)
        time_out();
    end
    while (!done);
    // One idle edge, so a following call never re-drives a strobe in this step
    @(posedge clk);
  endtask : bus

  task automatic rd_chk(input logic [13:0] a, input logic [7:0] m, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    `CHK(rd & {24'h000000, m}, {24'h000000, e});
  endtask : rd_chk

  task automatic t_regs;
    rd_chk(A_CFG, 8'hFF, CFG_RESET);
    rd_chk(A_NEN, 8'hFF, NAT_EN_RESET);
    bus(1'b0, 14'h0004, 8'h00);
    `CHK(resp, AXI_SLVERR);
    bus(1'b1, 14'h0004, 8'h55);
    `CHK(resp, AXI_SLVERR);
    bus(1'b1, A_NEN, 8'hFF);
    `CHK(resp, AXI_OKAY);
    rd_chk(A_NEN, 8'hFF, 8'hFF);
    bus(1'b1, A_NEN, 8'h00);
    $display("Test regs done");
  endtask : t_regs

  task automatic t_ts0;
    align_si <= 1'b1;
    nonalign <= 8'hA5;
    cyc(24);
    rd_chk(A_TS0, 8'hFF, 8'hE5);
    align_si <= 1'b0;
    nonalign <= 8'h5A;
    cyc(24);
    rd_chk(A_TS0, 8'hFF, 8'h1A);
    $display("Test ts0 done");
  endtask : t_ts0

  task automatic t_rai;
    nonalign <= 8'h00;
    cyc(48);
    bus(1'b1, A_CFG, 8'h05);
    nonalign <= 8'h20;
    cyc(16);
    rd_chk(A_ALM, 8'h80, 8'h00);
    cyc(160);
    rd_chk(A_ALM, 8'h80, 8'h80);
    nonalign <= 8'h00;
    cyc(40);
    rd_chk(A_ALM, 8'h80, 8'h00);
    bus(1'b1, A_CFG, 8'h01);
    nonalign <= 8'h20;
    cyc(40);
    rd_chk(A_ALM, 8'h80, 8'h80);
    nonalign <= 8'h00;
    cyc(40);
    rd_chk(A_ALM, 8'h80, 8'h00);
    $display("Test remote alarm done");
  endtask : t_rai

  task automatic t_rmai;
    ts16 <= 4'h4;
    cyc(128);
    rd_chk(A_ALM, 8'h40, 8'h00);
    cyc(640);
    rd_chk(A_ALM, 8'h40, 8'h40);
    ts16 <= 4'h0;
    cyc(300);
    rd_chk(A_ALM, 8'h40, 8'h00);
    $display("Test multiframe alarm done");
  endtask : t_rmai

  task automatic t_zd;
    ones <= 1'b1;
    cyc(1600);
    rd_chk(A_ALM, 8'h20, 8'h20);
    ones <= 1'b0;
    cyc(1100);
    rd_chk(A_ALM, 8'h20, 8'h00);
    bus(1'b1, A_CFG, 8'h09);
    ones <= 1'b1;
    cyc(520);
    rd_chk(A_ALM, 8'h20, 8'h00);
    cyc(1100);
    rd_chk(A_ALM, 8'h20, 8'h20);
    ones <= 1'b0;
    cyc(1600);
    rd_chk(A_ALM, 8'h20, 8'h00);
    bus(1'b1, A_CFG, 8'h01);
    $display("Test zero density done");
  endtask : t_zd

  task automatic t_alarm;
    oof  <= 1'b1;
    all1 <= 1'b1;
    cyc(10);
    rd_chk(A_ALM, 8'h0C, 8'h00);
    cyc(30);
    rd_chk(A_ALM, 8'h0C, 8'h0C);
    oof  <= 1'b0;
    all1 <= 1'b0;
    cyc(10);
    rd_chk(A_ALM, 8'h0C, 8'h0C);
    cyc(30);
    rd_chk(A_ALM, 8'h0C, 8'h00);
    $display("Test persistence alarms done");
  endtask : t_alarm

  task automatic wait_fresh;
    int n;
    n = 0;
    do
    begin
      bus(1'b0, A_HI, 8'h00);
      n++;
      if (n > 400)
        time_out();
    end
    while (!rd[6]);
  endtask : wait_fresh

  task automatic t_crc;
    bus(1'b0, A_HI, 8'h00);
    wait_fresh();
    crc_err <= 1'b1;
    cyc(300);
    crc_err <= 1'b0;
    wait_fresh();
    `CHK(rd[7:0] & 8'hC3, 8'h41);
    rd_chk(A_LO, 8'hFF, 8'h2C);
    cyc(2100);
    rd_chk(A_HI, 8'hC0, 8'hC0);
    rd_chk(A_HI, 8'hC0, 8'h00);
    $display("Test error count done");
  endtask : t_crc

  task automatic t_extra;
    ts16 <= 4'hB;
    cyc(300);
    rd_chk(A_HI, 8'h3C, 8'h2C);
    oof  <= 1'b1;
    ts16 <= 4'h6;
    cyc(300);
    rd_chk(A_HI, 8'h3C, 8'h2C);
    oof <= 1'b0;
    cyc(300);
    rd_chk(A_HI, 8'h3C, 8'h18);
    $display("Test extra bits done");
  endtask : t_extra

  task automatic t_cw;
    logic [2:0] e;
    for (int c = 0; c < 8; c++)
    begin
      e = c[2] ? {1'b0, 2'(c)} : ((c == 0) ? 3'h4 : 3'h7);
      bus(1'b1, A_NEN, {3'(c), 5'h10});
      `CHK(cw_sel, e);
    end
    nat_chg <= 5'h10;
    cyc(2);
    `CHK(irq_n, 1'b0);
    rd_chk({IDX_NAT_IRQ_STAT, 2'b00}, 8'hFF, 8'h10);
    nat_chg <= 5'h0F;
    cyc(2);
    `CHK(irq_n, 1'b1);
    $display("Test codeword done");
  endtask : t_cw

  task automatic t_hold;
    nat_chg <= 5'h10;
    bus(1'b1, A_CFG, 8'h03);
    rd_chk(A_NEN, 8'hFF, 8'h00);
    `CHK(irq_n, 1'b1);
    rd_chk(A_TS0, 8'hFF, 8'h00);
    bus(1'b1, A_CFG, 8'h00);
    bus(1'b1, A_NEN, 8'hFF);
    rd_chk(A_NEN, 8'hFF, 8'h00);
    rd_chk(A_ALM, 8'hFF, 8'h00);
    bus(1'b1, A_CFG, 8'h01);
    nat_chg <= 5'h00;
    $display("Test held reset done");
  endtask : t_hold

  initial
  begin
    rst_n = 1'b0;
    {oof, all1, crc_err, align_si, ones, aw_valid, w_valid, b_ready, ar_valid, r_ready} = '0;
    {nonalign, ts16, nat_chg, aw_addr, ar_addr, w_data} = '0;
    failures = 0;
    checks = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_ts0();
    t_rai();
    t_rmai();
    t_zd();
    t_alarm();
    t_crc();
    t_extra();
    t_cw();
    t_hold();
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
